// [core/dps_defs.vh]
`ifndef DPS_DEFS_VH
`define DPS_DEFS_VH
// Wishbone register byte offsets
`define DPS_REG_CTRL      8'h00
`define DPS_REG_STATUS    8'h04
`define DPS_REG_EVT       8'h08
`define DPS_REG_EVT_CLR   8'h0C
`define DPS_REG_EVT_EN    8'h10
`define DPS_REG_PWMDIV    8'h14
// Control fields
`define DPS_CTRL_SWEN     0
`define DPS_CTRL_RESET    32'h0000_0000
// Event bits
`define DPS_EVT_OC        0
`define DPS_EVT_OV        1
`define DPS_EVT_UV        2
`define DPS_EVT_STATE     3
`define DPS_EVT_W         4
// States
`define DPS_ST_OFF        2'h0
`define DPS_ST_STBY       2'h1
`define DPS_ST_RUN        2'h2
// Timing
`define DPS_CLK_MHZ       250
`define DPS_PWM_KHZ       400
`define DPS_PWM_PERIOD    (`DPS_CLK_MHZ * 1000 / `DPS_PWM_KHZ)
`define DPS_FAULT_CYC     4
`define DPS_TT_SS_CYC     128
`define DPS_OUTPUT_GOOD_FLAG_US      200
`define DPS_OUTPUT_GOOD_FLAG_CYC     (`DPS_OUTPUT_GOOD_FLAG_US * `DPS_CLK_MHZ)
`define DPS_DEAD_CYC      8
`define DPS_SS_STEP_CYC   16
`endif

// [core/dps_sync2.v]
`timescale 1ns/10ps
module dps_sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         reset_n,
  // Data
  input  wire [W-1:0] dataIn,
  output reg  [W-1:0] dataOut
);
  reg [W-1:0] stage1;

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1  <= {W{1'b0}};
      dataOut <= {W{1'b0}};
    end
    else
    begin
      stage1  <= dataIn;
      dataOut <= stage1;
    end
  end
endmodule // dps_sync2

// [core/dps_fault_filter.v]
`timescale 1ns/10ps
module dps_fault_filter #(
  parameter N = 4
) (
  // Clock and reset
  input  wire sys_clk,
  input  wire reset_n,
  // Condition and latch control
  input  wire cond,
  input  wire clear,
  output reg  latched
);
  reg [3:0] count;

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count   <= 4'h0;
      latched <= 1'b0;
    end
    else if (clear)
    begin
      count   <= 4'h0;
      latched <= 1'b0;
    end
    else
    begin
      count <= cond ? ((count == N[3:0]) ? count : count + 4'h1) : 4'h0;
      if (cond && (count == N[3:0] - 4'h1))
        latched <= 1'b1;
    end
  end
endmodule // dps_fault_filter

// [core/dps_power_ctrl.v]
`timescale 1ns/10ps
`include "dps_defs.vh"
module dps_power_ctrl #(
  parameter OUTPUT_GOOD_FLAG_CYC = `DPS_OUTPUT_GOOD_FLAG_CYC,
  parameter BG_CYC    = 16
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        reset_n,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Pins and analog status
  input  wire        mainEnablePin,
  input  wire        terminationEnablePin,
  input  wire        forcedPwmSelect,
  input  wire        inputSensePin,
  input  wire        controlSupplyGood,
  input  wire        railRegDetect,
  input  wire        overcurrentCmp,
  input  wire        overvoltageCmp,
  input  wire        undervoltageCmp,
  // Outputs
  output reg         highSideGate,
  output reg         lowSideGate,
  output reg         memoryRailEnable,
  output reg         bufferedReferenceEnable,
  output reg         terminationOutputEnable,
  output reg         terminationCurrentHigh,
  output reg         powerSavingMode,
  output reg         softStartActive,
  output reg  [7:0]  softStartLevel,
  output reg         memoryRailInRegulation,
  output reg         outputGoodLow_n,
  output reg         bandgapReady,
  output reg         supplyOk,
  output reg  [1:0]  powerState,
  output wire        irq
);
  localparam ST_OFF  = `DPS_ST_OFF;
  localparam ST_STBY = `DPS_ST_STBY;
  localparam ST_RUN  = `DPS_ST_RUN;
  localparam [9:0] PWM_PER = `DPS_PWM_PERIOD;
  localparam [3:0] DEAD    = `DPS_DEAD_CYC;

  wire [2:0] syncIn;
  wire       enSync;
  wire       ttSync;
  wire       fpwmSync;
  wire       ocLatch;
  wire       ovLatch;
  wire       uvLatch;
  wire       faultClear;
  wire       anyFault;
  wire       swEn;
  reg  [31:0] ctrlReg;
  reg  [9:0]  pwmDuty;
  reg  [3:0]  evtStat;
  reg  [3:0]  evtEn;
  reg  [7:0]  bgCount;
  reg  [1:0]  nextState;
  reg  [9:0]  pwmCount;
  reg         pwmRaw;
  reg         pwmPrev;
  reg  [3:0]  deadCount;
  reg  [3:0]  ssDiv;
  reg  [7:0]  ttCount;
  reg  [31:0] pgCount;
  reg  [1:0]  prevState;
  reg         wasOff;
  reg  [31:0] readMux;
  reg  [3:0]  evtSet;

  // Input synchronisers
  dps_sync2 #(.W(3)) uSync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .dataIn  ({mainEnablePin, terminationEnablePin, forcedPwmSelect}),
    .dataOut (syncIn)
  );
  assign enSync   = syncIn[2] & swEn;
  assign ttSync   = syncIn[1];
  assign fpwmSync = syncIn[0];
  assign swEn     = ctrlReg[`DPS_CTRL_SWEN] == 1'b0;

  // Bandgap start and supply monitor
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bgCount      <= 8'h00;
      bandgapReady <= 1'b0;
      supplyOk     <= 1'b0;
    end
    else
    begin
      if (!enSync)
        bgCount <= 8'h00;
      else if (bgCount != BG_CYC[7:0])
        bgCount <= bgCount + 8'h01;
      bandgapReady <= enSync && (bgCount == BG_CYC[7:0]);
      supplyOk     <= bandgapReady && controlSupplyGood;
    end
  end

  // Faults clear when enable or supply is cycled
  assign faultClear = !enSync || !controlSupplyGood;
  dps_fault_filter #(.N(`DPS_FAULT_CYC)) uOc (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .cond    (overcurrentCmp && powerState != ST_OFF),
    .clear   (faultClear),
    .latched (ocLatch)
  );
  dps_fault_filter #(.N(`DPS_FAULT_CYC)) uOv (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .cond    (overvoltageCmp && powerState != ST_OFF),
    .clear   (faultClear),
    .latched (ovLatch)
  );
  dps_fault_filter #(.N(`DPS_FAULT_CYC)) uUv (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .cond    (undervoltageCmp && powerState != ST_OFF),
    .clear   (faultClear),
    .latched (uvLatch)
  );
  assign anyFault = ocLatch | ovLatch | uvLatch;

  // State decode
  always @*
  begin
    nextState = ST_OFF;
    case (1'b1)
      (!supplyOk || !inputSensePin || !enSync): nextState = ST_OFF;
      ttSync:  nextState = ST_RUN;
      default: nextState = ST_STBY;
    endcase
  end

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      powerState <= ST_OFF;
      prevState  <= ST_OFF;
      wasOff     <= 1'b1;
    end
    else
    begin
      powerState <= nextState;
      prevState  <= powerState;
      if (powerState == ST_OFF)
        wasOff <= 1'b1;
      else if (softStartLevel == 8'hFF)
        wasOff <= 1'b0;
    end
  end

  // Output modes
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      memoryRailEnable        <= 1'b0;
      bufferedReferenceEnable <= 1'b0;
      terminationOutputEnable <= 1'b0;
      powerSavingMode         <= 1'b0;
    end
    else
    begin
      memoryRailEnable        <= powerState != ST_OFF && !ocLatch;
      bufferedReferenceEnable <= powerState != ST_OFF && !ocLatch;
      terminationOutputEnable <= powerState == ST_RUN && !ocLatch
                                 && memoryRailInRegulation;
      powerSavingMode         <= powerState == ST_STBY && fpwmSync;
    end
  end

  // Soft-start ramp of the rail
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      softStartLevel  <= 8'h00;
      softStartActive <= 1'b0;
      ssDiv           <= 4'h0;
    end
    else if (powerState == ST_OFF)
    begin
      softStartLevel  <= 8'h00;
      softStartActive <= 1'b0;
      ssDiv           <= 4'h0;
    end
    else if (softStartLevel != 8'hFF)
    begin
      softStartActive <= 1'b1;
      ssDiv           <= ssDiv + 4'h1;
      if (ssDiv == 4'hF)
        softStartLevel <= softStartLevel + 8'h01;
    end
    else
      softStartActive <= 1'b0;
  end

  // Regulation flag and power-good release
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      memoryRailInRegulation <= 1'b0;
      pgCount                <= 32'h0000_0000;
      outputGoodLow_n        <= 1'b0;
    end
    else
    begin
      memoryRailInRegulation <= powerState != ST_OFF && softStartLevel == 8'hFF
                                && railRegDetect && !anyFault;
      if (powerState == ST_OFF || anyFault)
      begin
        pgCount         <= 32'h0000_0000;
        outputGoodLow_n <= 1'b0;
      end
      else if (memoryRailInRegulation || pgCount == OUTPUT_GOOD_FLAG_CYC - 1)
        outputGoodLow_n <= 1'b1;
      else
        pgCount <= pgCount + 32'h0000_0001;
    end
  end

  // Termination soft-start current limit
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ttCount                <= 8'h00;
      terminationCurrentHigh <= 1'b0;
    end
    else if (!terminationOutputEnable)
    begin
      ttCount                <= 8'h00;
      terminationCurrentHigh <= 1'b0;
    end
    else if (ttCount != `DPS_TT_SS_CYC - 1)
      ttCount <= ttCount + 8'h01;
    else
      terminationCurrentHigh <= 1'b1;
  end

  // Fixed-frequency modulator with dead time
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pwmCount     <= 10'h000;
      pwmRaw       <= 1'b0;
      pwmPrev      <= 1'b0;
      deadCount    <= 4'h0;
      highSideGate <= 1'b0;
      lowSideGate  <= 1'b0;
    end
    else
    begin
      pwmCount <= (pwmCount == PWM_PER - 10'h001) ? 10'h000
                  : pwmCount + 10'h001;
      pwmRaw   <= {8'h00, pwmCount} < ((pwmDuty * {10'h000, softStartLevel}) >> 8);
      pwmPrev  <= pwmRaw;
      if (pwmRaw != pwmPrev)
        deadCount <= DEAD;
      else if (deadCount != 4'h0)
        deadCount <= deadCount - 4'h1;
      if (powerState == ST_OFF || anyFault)
      begin
        highSideGate <= 1'b0;
        lowSideGate  <= 1'b0;
      end
      else if (pwmRaw != pwmPrev || deadCount != 4'h0)
      begin
        highSideGate <= 1'b0;
        lowSideGate  <= 1'b0;
      end
      else
      begin
        highSideGate <= pwmRaw;
        lowSideGate  <= !pwmRaw && !(powerSavingMode && !railRegDetect);
      end
    end
  end

  // Event capture, set wins over clear
  always @*
  begin
    evtSet = 4'h0;
    evtSet[`DPS_EVT_OC]    = ocLatch;
    evtSet[`DPS_EVT_OV]    = ovLatch;
    evtSet[`DPS_EVT_UV]    = uvLatch;
    evtSet[`DPS_EVT_STATE] = powerState != prevState;
  end
  assign irq = |(evtStat & evtEn);

  // Wishbone register file
  always @*
  begin
    readMux = 32'h0000_0000;
    case (wb_adr_i)
      `DPS_REG_CTRL:   readMux = ctrlReg;
      `DPS_REG_STATUS: readMux = {21'h00_0000, wasOff, anyFault, outputGoodLow_n,
                                  memoryRailInRegulation, supplyOk, bandgapReady,
                                  uvLatch, ovLatch, ocLatch, powerState};
      `DPS_REG_EVT:    readMux = {28'h000_0000, evtStat};
      `DPS_REG_EVT_EN: readMux = {28'h000_0000, evtEn};
      `DPS_REG_PWMDIV: readMux = {22'h00_0000, pwmDuty};
      default:         readMux = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrlReg  <= `DPS_CTRL_RESET;
      evtStat  <= 4'h0;
      evtEn    <= 4'h0;
      pwmDuty  <= PWM_PER >> 1;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o)
        wb_dat_o <= readMux;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
          && wb_adr_i == `DPS_REG_EVT_CLR)
        evtStat <= (evtStat & ~wb_dat_i[3:0]) | evtSet;
      else
        evtStat <= evtStat | evtSet;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i)
      begin
        case (wb_adr_i)
          `DPS_REG_CTRL:
            if (wb_sel_i[0])
              ctrlReg[7:0] <= wb_dat_i[7:0];
          `DPS_REG_EVT_EN:
            if (wb_sel_i[0])
              evtEn <= wb_dat_i[3:0];
          `DPS_REG_PWMDIV:
          begin
            if (wb_sel_i[0])
              pwmDuty[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
              pwmDuty[9:8] <= wb_dat_i[9:8];
          end
          default:
            ctrlReg <= ctrlReg;
        endcase
      end
    end
  end
endmodule // dps_power_ctrl

// [bench/dps_power_ctrl_sva.sv]
`timescale 1ns/10ps
`include "dps_defs.vh"
module dps_power_ctrl_sva #(
  parameter OUTPUT_GOOD_FLAG_CYC = 200,
  parameter BG_CYC    = 16
) (
  // Clock and reset
  input wire       sys_clk,
  input wire       reset_n,
  // Pins and comparators
  input wire       mainEnablePin,
  input wire       controlSupplyGood,
  input wire       overcurrentCmp,
  input wire       overvoltageCmp,
  input wire       undervoltageCmp,
  // Outputs
  input wire       highSideGate,
  input wire       lowSideGate,
  input wire       memoryRailEnable,
  input wire       bufferedReferenceEnable,
  input wire       terminationOutputEnable,
  input wire       terminationCurrentHigh,
  input wire       outputGoodLow_n,
  input wire       bandgapReady,
  input wire       supplyOk,
  input wire [1:0] powerState
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  reg  [15:0] runCnt;
  reg  [7:0]  ttCnt;
  reg  [7:0]  enCnt;
  reg         faultSeen;
  wire        isOff  = (powerState == `DPS_ST_OFF);
  wire        anyCmp = overcurrentCmp | overvoltageCmp | undervoltageCmp;
  // Cycle counters for long waits
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      runCnt    <= 16'h0000;
      ttCnt     <= 8'h00;
      enCnt     <= 8'h00;
      faultSeen <= 1'b0;
    end
    else
    begin
      faultSeen <= !isOff && (faultSeen || anyCmp);
      runCnt    <= (powerState != `DPS_ST_RUN || faultSeen || anyCmp) ? 16'h0000 :
                   runCnt + {15'h0000, runCnt < OUTPUT_GOOD_FLAG_CYC + 8};
      ttCnt     <= terminationOutputEnable ? ttCnt + {7'h00, ttCnt != 8'hFF} : 8'h00;
      enCnt     <= mainEnablePin ? enCnt + {7'h00, enCnt != 8'hFF} : 8'h00;
    end
  end
  sequence s_oc4;
    (!isOff && overcurrentCmp) [*4];
  endsequence
  sequence s_ov4;
    (!isOff && overvoltageCmp) [*4];
  endsequence
  sequence s_uv4;
    (!isOff && undervoltageCmp) [*4];
  endsequence
  sequence s_gatesOff;
    (!highSideGate && !lowSideGate) [*3];
  endsequence
  property p_gates;
    !(highSideGate && lowSideGate);
  endproperty
  property p_off;
    isOff [*2] |-> !highSideGate && !lowSideGate && !memoryRailEnable &&
      !bufferedReferenceEnable && !terminationOutputEnable && !outputGoodLow_n;
  endproperty
  property p_stby;
    (powerState == `DPS_ST_STBY) [*2] |-> !terminationOutputEnable;
  endproperty
  property p_bg;
    enCnt == BG_CYC + 8 |-> bandgapReady;
  endproperty
  property p_sup;
    supplyOk |-> $past(controlSupplyGood) && $past(bandgapReady);
  endproperty
  property p_oc;
    s_oc4 |-> ##2 (!highSideGate && !lowSideGate && !memoryRailEnable &&
      !bufferedReferenceEnable && !terminationOutputEnable) [*3];
  endproperty
  property p_ov;
    s_ov4 |-> ##2 s_gatesOff;
  endproperty
  property p_uv;
    s_uv4 |-> ##2 s_gatesOff;
  endproperty
  property p_pg;
    runCnt == OUTPUT_GOOD_FLAG_CYC + 4 |-> outputGoodLow_n;
  endproperty
  property p_tt;
    terminationOutputEnable |-> terminationCurrentHigh == (ttCnt >= `DPS_TT_SS_CYC);
  endproperty
  a_gates: assert property (p_gates) else $error("Gates both high");
  a_off: assert property (p_off) else $error("Output active in off");
  a_stby: assert property (p_stby) else $error("Termination on in standby");
  a_bg: assert property (p_bg) else $error("Bandgap ready missing");
  a_sup: assert property (p_sup) else $error("Supply ok without cause");
  a_oc: assert property (p_oc) else $error("Overcurrent not latched");
  a_ov: assert property (p_ov) else $error("Overvoltage not latched");
  a_uv: assert property (p_uv) else $error("Undervoltage not latched");
  a_pg: assert property (p_pg) else $error("Power good late");
  a_tt: assert property (p_tt) else $error("Current limit raised early");
endmodule // dps_power_ctrl_sva

bind dps_power_ctrl dps_power_ctrl_sva #(.OUTPUT_GOOD_FLAG_CYC(OUTPUT_GOOD_FLAG_CYC), .BG_CYC(BG_CYC)) u_sva (
  .sys_clk, .reset_n, .mainEnablePin, .controlSupplyGood, .overcurrentCmp, .overvoltageCmp,
  .undervoltageCmp, .highSideGate, .lowSideGate, .memoryRailEnable, .bufferedReferenceEnable,
  .terminationOutputEnable, .terminationCurrentHigh, .outputGoodLow_n, .bandgapReady,
  .supplyOk, .powerState);

// [bench/dps_host_model.sv]
`timescale 1ns/10ps
module dps_host_model (
  // Clock
  input  wire sys_clk,
  // Requests from the bench
  input  wire wantEnable,
  input  wire wantTermination,
  input  wire wantPowerSave,
  // Pins
  output reg  mainEnablePin,
  output reg  terminationEnablePin,
  output reg  forcedPwmSelect,
  input  wire outputGoodLow_n,
  output wire powerGoodLine
);
  initial
  begin
    mainEnablePin        = 1'b0;
    terminationEnablePin = 1'b0;
    forcedPwmSelect      = 1'b0;
  end
  // Pins change only after a clock edge
  always @(posedge sys_clk)
  begin
    mainEnablePin        <= wantEnable;
    terminationEnablePin <= wantTermination;
    forcedPwmSelect      <= wantPowerSave;
  end
  // Power-good line driven both high and low, no open drain
  assign powerGoodLine = outputGoodLow_n ? 1'b1 : 1'b0;
endmodule // dps_host_model

// [bench/test_dps_power_ctrl.sv]
`timescale 1ns/10ps
`include "dps_defs.vh"
module test_dps_power_ctrl;
  localparam PG = 200;
  reg         sys_clk = 1'b0;
  reg         reset_n = 1'b0;
  reg         wb_cyc_i = 1'b0;
  reg         wb_stb_i = 1'b0;
  reg         wb_we_i = 1'b0;
  reg  [7:0]  wb_adr_i = 8'h00;
  reg  [3:0]  wb_sel_i = 4'h0;
  reg  [31:0] wb_dat_i = 32'h0000_0000;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o;
  reg         wantEnable = 1'b0;
  reg         wantTermination = 1'b0;
  reg         wantPowerSave = 1'b0;
  reg         inputSensePin = 1'b0;
  reg         controlSupplyGood = 1'b0;
  reg         railRegDetect = 1'b0;
  reg         overcurrentCmp = 1'b0;
  reg         overvoltageCmp = 1'b0;
  reg         undervoltageCmp = 1'b0;
  wire        mainEnablePin, terminationEnablePin, forcedPwmSelect, powerGoodLine;
  wire        highSideGate, lowSideGate, memoryRailEnable, bufferedReferenceEnable;
  wire        terminationOutputEnable, terminationCurrentHigh, powerSavingMode, irq;
  wire        softStartActive, memoryRailInRegulation, outputGoodLow_n, bandgapReady, supplyOk;
  wire [7:0]  softStartLevel;
  wire [1:0]  powerState;
  reg  [31:0] rd;
  integer     n_errors = 0;
  integer     checked = 0;
  integer     hsRises = 0;
  integer     i;
  integer     k;
  always #2 sys_clk = ~sys_clk;
  always @(posedge highSideGate) hsRises = hsRises + 1;
  dps_host_model host (.sys_clk, .wantEnable, .wantTermination, .wantPowerSave, .mainEnablePin,
    .terminationEnablePin, .forcedPwmSelect, .outputGoodLow_n, .powerGoodLine);
  dps_power_ctrl #(.OUTPUT_GOOD_FLAG_CYC(PG)) uut (.sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mainEnablePin, .terminationEnablePin,
    .forcedPwmSelect, .inputSensePin, .controlSupplyGood, .railRegDetect, .overcurrentCmp,
    .overvoltageCmp, .undervoltageCmp, .highSideGate, .lowSideGate, .memoryRailEnable,
    .bufferedReferenceEnable, .terminationOutputEnable, .terminationCurrentHigh, .powerSavingMode,
    .softStartActive, .softStartLevel, .memoryRailInRegulation, .outputGoodLow_n, .bandgapReady,
    .supplyOk, .powerState, .irq);
  task wrap_up;
  begin
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task check(input [31:0] seen, input [31:0] want);
  begin
    checked = checked + 1;
    if (seen !== want)
    begin
      n_errors = n_errors + 1;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, want);
    end
  end
  endtask
  // One classic Wishbone cycle, read data lands in rd
  task wb(input we, input [7:0] adr, input [31:0] dat);
    integer t;
  begin
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    t = 0;
    @(posedge sys_clk);
    while (wb_ack_o !== 1'b1 && t < 20)
    begin
      @(posedge sys_clk);
      t = t + 1;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
    if (t == 20)
    begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end
  endtask
  task wait_state(input [1:0] s);
    integer t;
  begin
    t = 0;
    while (powerState !== s && t < 300)
    begin
      @(posedge sys_clk);
      t = t + 1;
    end
    if (t == 300)
    begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    wb(1'b0, `DPS_REG_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0400);
    wb(1'b0, `DPS_REG_PWMDIV, 32'h0000_0000);
    check(rd, 32'h0000_0138);
    wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h1C, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    // Power up into run
    controlSupplyGood <= 1'b1;
    inputSensePin     <= 1'b1;
    wantTermination   <= 1'b1;
    wantEnable        <= 1'b1;
    wait_state(`DPS_ST_RUN);
    @(posedge sys_clk);
    check({bandgapReady, supplyOk, softStartActive, powerGoodLine}, 4'hE);
    repeat (PG + 4) @(posedge sys_clk);
    check(powerGoodLine, 1'b1);
    railRegDetect <= 1'b1;
    repeat (4400) @(posedge sys_clk);
    check({memoryRailInRegulation, softStartActive}, 2'h2);
    check(softStartLevel, 8'hFF);
    check({memoryRailEnable, bufferedReferenceEnable, terminationOutputEnable}, 3'h7);
    check(terminationCurrentHigh, 1'b1);
    hsRises = 0;
    repeat (6250) @(posedge sys_clk);
    check(hsRises >= 9 && hsRises <= 11, 1'b1);
    // Event, mask and clear
    wb(1'b0, `DPS_REG_EVT, 32'h0000_0000);
    check({rd[3], irq}, 2'h2);
    wb(1'b1, `DPS_REG_EVT_EN, 32'h0000_0008);
    check(irq, 1'b1);
    wb(1'b0, `DPS_REG_EVT_EN, 32'h0000_0000);
    check(rd, 32'h0000_0008);
    wb(1'b1, `DPS_REG_EVT_CLR, 32'h0000_000F);
    check(irq, 1'b0);
    // Standby with and without power saving
    wantTermination <= 1'b0;
    wantPowerSave   <= 1'b1;
    wait_state(`DPS_ST_STBY);
    repeat (2) @(posedge sys_clk);
    check({terminationOutputEnable, powerSavingMode, memoryRailEnable}, 3'h3);
    wantPowerSave <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check(powerSavingMode, 1'b0);
    wantTermination <= 1'b1;
    wait_state(`DPS_ST_RUN);
    // Three comparators: three-cycle blip ignored, six cycles latch
    for (i = 0; i < 3; i = i + 1)
    begin
      {undervoltageCmp, overvoltageCmp, overcurrentCmp} <= 3'h1 << i;
      repeat (3) @(posedge sys_clk);
      {undervoltageCmp, overvoltageCmp, overcurrentCmp} <= 3'h0;
      repeat (4) @(posedge sys_clk);
      wb(1'b0, `DPS_REG_STATUS, 32'h0000_0000);
      check({rd[9], rd[4:2]}, 4'h0);
      {undervoltageCmp, overvoltageCmp, overcurrentCmp} <= 3'h1 << i;
      repeat (6) @(posedge sys_clk);
      {undervoltageCmp, overvoltageCmp, overcurrentCmp} <= 3'h0;
      repeat (6) @(posedge sys_clk);
      check({highSideGate, lowSideGate}, 2'h0);
      if (i == 0)
        check({memoryRailEnable, terminationOutputEnable}, 2'h0);
      wb(1'b0, `DPS_REG_STATUS, 32'h0000_0000);
      check({rd[9], rd[4:2]}, {1'b1, 3'h1 << i});
      wb(1'b0, `DPS_REG_EVT, 32'h0000_0000);
      check(rd[i], 1'b1);
      wb(1'b1, `DPS_REG_EVT_CLR, 32'h0000_000F);
      wantEnable <= 1'b0;
      wait_state(`DPS_ST_OFF);
      wantEnable <= 1'b1;
      wait_state(`DPS_ST_RUN);
      repeat (20) @(posedge sys_clk);
      wb(1'b0, `DPS_REG_STATUS, 32'h0000_0000);
      check(rd[9], 1'b0);
    end
    // Each off cause: sense low, supply low, software disable
    for (k = 0; k < 3; k = k + 1)
    begin
      inputSensePin     <= (k != 0);
      controlSupplyGood <= (k != 1);
      wb(1'b1, `DPS_REG_CTRL, {31'h0000_0000, k == 2});
      wait_state(`DPS_ST_OFF);
      repeat (2) @(posedge sys_clk);
      check({highSideGate, lowSideGate, memoryRailEnable, bufferedReferenceEnable,
        terminationOutputEnable, powerGoodLine}, 6'h00);
      inputSensePin     <= 1'b1;
      controlSupplyGood <= 1'b1;
      wb(1'b1, `DPS_REG_CTRL, 32'h0000_0000);
      wait_state(`DPS_ST_RUN);
    end
    wrap_up;
  end
endmodule // test_dps_power_ctrl
